// >>> design/pse_pkg.sv
// Package of offsets, field layout, reset values and summary bit positions
package pse_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PSE_OFS_PWR_VIEW = 8'h02;
  localparam logic [7:0] PSE_OFS_PWR_TAKE = 8'h03;
  localparam logic [7:0] PSE_OFS_PRB_VIEW = 8'h04;
  localparam logic [7:0] PSE_OFS_PRB_TAKE = 8'h05;
  localparam logic [7:0] PSE_OFS_DRP_VIEW = 8'h06;
  localparam logic [7:0] PSE_OFS_DRP_TAKE = 8'h07;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int PSE_NUM_PORTS = 4;
  localparam int PSE_HI_LSB = 4;
  localparam int PSE_LO_LSB = 0;
  localparam logic [7:0] PSE_EVT_RESET = 8'h00;
  localparam logic [7:0] PSE_RD_UNMAPPED = 8'h00;
  // ****************************************
  // Quad summary bit positions
  // ****************************************
  localparam int PSE_SUM_PI_FAULT = 5;
  localparam int PSE_SUM_CLASS = 4;
  localparam int PSE_SUM_DETECT = 3;
  localparam int PSE_SUM_DROP = 2;
  localparam int PSE_SUM_PGOOD = 1;
  localparam int PSE_SUM_PENABLE = 0;
endpackage : pse_pkg

// >>> design/pse_change_det.sv
// Per-port result tracker flagging updates or changes
`timescale 1ns/100ps
module pse_change_det #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sampled value
  input wire logic [W-1:0] value,
  input wire logic sample,
  input wire logic change_only,
  // Event
  output logic hit
);
  logic [W-1:0] last;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last <= '0;
    end else if (sample) begin
      last <= value;
    end
  end

  // Update or change of the value
  assign hit = sample && (!change_only || (value != last));
endmodule : pse_change_det

// >>> design/pse_flag_bank.sv
// Sticky event flag byte with set winning over clear
`timescale 1ns/100ps
module pse_flag_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] flags
);
  // Held until cleared, a same-cycle set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= pse_pkg::PSE_EVT_RESET;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule : pse_flag_bank

// >>> design/pse_event_regs.sv
// Quad event flag registers with read-only and clear-on-read views
// What this block does
// - Powered-ok change sets upper power flags
// - Switch-on change sets lower power flags
// - Any powered-ok flag raises its summary
// - Any switch-on flag raises its summary
// - Classification update sets upper probe flags
// - Detection update sets lower probe flags
// - Probe flags raise class and detect summaries
// - Change-only option limits detection flags
// - Classification counts only after valid signature
// - Four-pair class completion updates link check
// - Signature dropout on a powered-ok port sets upper fault flags
// - Two-pair overpower on a powered-ok port sets lower fault flags
// - Any dropout flag raises dropout summary
// - Any overpower flag raises fault summary
// - Even address views, odd address clears
// - Summary drops only when all flags zero
// - Shutdown, resets and clear-all clear flags
`timescale 1ns/100ps
module pse_event_regs #(
  parameter int DW = 4,
  parameter int CW = 4,
  parameter int LW = 2,
  parameter logic [DW-1:0] VALID_SIG_CODE = 4'h4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Port power status
  input wire logic [3:0] power_good,
  input wire logic [3:0] power_enable,
  // Probe results
  input wire logic [3:0] detect_update,
  input wire logic [4*DW-1:0] detection_result,
  input wire logic [3:0] class_update,
  input wire logic [4*CW-1:0] classification_result,
  input wire logic detect_change_only,
  // Pair link check
  input wire logic [1:0] four_pair_mode,
  input wire logic [2*LW-1:0] link_check_in,
  output logic [2*LW-1:0] pair_link_check_result,
  // Fault events
  input wire logic [3:0] mps_dropout,
  input wire logic [3:0] two_pair_overpower,
  // Clearing actions
  input wire logic [3:0] port_clear,
  input wire logic clear_all,
  // Quad summary
  output logic [7:0] quad_summary
);
  // ****************************************
  // Event detection per port
  // ****************************************
  logic [3:0] pg_hit;
  logic [3:0] en_hit;
  logic [3:0] det_hit;
  logic [3:0] cls_hit;
  logic [3:0] cls_raw;
  logic [3:0] sig_valid;

  for (genvar p = 0; p < pse_pkg::PSE_NUM_PORTS; p++) begin : g_port
    pse_change_det #(.W(1)) u_pg (
      .clk(clk),
      .arst_n(arst_n),
      .value(power_good[p]),
      .sample(1'b1),
      .change_only(1'b1),
      .hit(pg_hit[p])
    );
    pse_change_det #(.W(1)) u_en (
      .clk(clk),
      .arst_n(arst_n),
      .value(power_enable[p]),
      .sample(1'b1),
      .change_only(1'b1),
      .hit(en_hit[p])
    );
    pse_change_det #(.W(DW)) u_det (
      .clk(clk),
      .arst_n(arst_n),
      .value(detection_result[p*DW +: DW]),
      .sample(detect_update[p]),
      .change_only(detect_change_only),
      .hit(det_hit[p])
    );
    pse_change_det #(.W(CW)) u_cls (
      .clk(clk),
      .arst_n(arst_n),
      .value(classification_result[p*CW +: CW]),
      .sample(class_update[p]),
      .change_only(1'b0),
      .hit(cls_raw[p])
    );
    assign sig_valid[p] = detection_result[p*DW +: DW] == VALID_SIG_CODE;
    assign cls_hit[p] = cls_raw[p] && sig_valid[p];
  end

  // ****************************************
  // Clear sources
  // ****************************************
  logic take_pwr;
  logic take_prb;
  logic take_drp;
  logic [7:0] port_clr;

  assign take_pwr = rd_en && (rd_addr == pse_pkg::PSE_OFS_PWR_TAKE);
  assign take_prb = rd_en && (rd_addr == pse_pkg::PSE_OFS_PRB_TAKE);
  assign take_drp = rd_en && (rd_addr == pse_pkg::PSE_OFS_DRP_TAKE);
  assign port_clr = {port_clear, port_clear} | {8{clear_all}};

  // ****************************************
  // Flag registers
  // ****************************************
  logic [7:0] pwr_flags;
  logic [7:0] prb_flags;
  logic [7:0] drp_flags;

  pse_flag_bank #(.W(8)) u_pwr (
    .clk(clk),
    .arst_n(arst_n),
    .set({pg_hit, en_hit}),
    .clr(port_clr | {8{take_pwr}}),
    .flags(pwr_flags)
  );
  pse_flag_bank #(.W(8)) u_prb (
    .clk(clk),
    .arst_n(arst_n),
    .set({cls_hit, det_hit}),
    .clr(port_clr | {8{take_prb}}),
    .flags(prb_flags)
  );
  pse_flag_bank #(.W(8)) u_drp (
    .clk(clk),
    .arst_n(arst_n),
    .set({mps_dropout & power_good, two_pair_overpower & power_good}),
    .clr(port_clr | {8{take_drp}}),
    .flags(drp_flags)
  );

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] next_rd_data;

  always_comb begin
    unique case (rd_addr)
      pse_pkg::PSE_OFS_PWR_VIEW, pse_pkg::PSE_OFS_PWR_TAKE: next_rd_data = pwr_flags;
      pse_pkg::PSE_OFS_PRB_VIEW, pse_pkg::PSE_OFS_PRB_TAKE: next_rd_data = prb_flags;
      pse_pkg::PSE_OFS_DRP_VIEW, pse_pkg::PSE_OFS_DRP_TAKE: next_rd_data = drp_flags;
      default: next_rd_data = pse_pkg::PSE_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= pse_pkg::PSE_RD_UNMAPPED;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // ****************************************
  // Quad summary
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quad_summary <= pse_pkg::PSE_EVT_RESET;
    end else begin
      quad_summary <= 8'h00;
      quad_summary[pse_pkg::PSE_SUM_PGOOD] <= |pwr_flags[7:4];
      quad_summary[pse_pkg::PSE_SUM_PENABLE] <= |pwr_flags[3:0];
      quad_summary[pse_pkg::PSE_SUM_CLASS] <= |prb_flags[7:4];
      quad_summary[pse_pkg::PSE_SUM_DETECT] <= |prb_flags[3:0];
      quad_summary[pse_pkg::PSE_SUM_DROP] <= |drp_flags[7:4];
      quad_summary[pse_pkg::PSE_SUM_PI_FAULT] <= |drp_flags[3:0];
    end
  end

  // ****************************************
  // Pair link check result
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_link_check_result <= '0;
    end else begin
      for (int q = 0; q < 2; q++) begin
        if (four_pair_mode[q] && (cls_hit[2*q] || cls_hit[2*q+1])) begin
          pair_link_check_result[q*LW +: LW] <= link_check_in[q*LW +: LW];
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  for (genvar p = 0; p < pse_pkg::PSE_NUM_PORTS; p++) begin : g_chk
    a_pg_flag_set: assert property ($changed(power_good[p]) |-> ##1 pwr_flags[4+p])
      else $error("powered-ok change did not set flag");
    a_en_flag_set: assert property ($changed(power_enable[p]) |-> ##1 pwr_flags[p])
      else $error("switch-on change did not set flag");
    a_cls_flag_set: assert property (
      class_update[p] && detection_result[p*DW +: DW] == VALID_SIG_CODE |=> prb_flags[4+p])
      else $error("accepted class update did not set flag");
    a_det_flag_set: assert property (
      detect_update[p] && !detect_change_only |=> prb_flags[p])
      else $error("detection update did not set flag");
    a_det_needs_update: assert property (
      $rose(prb_flags[p]) |-> $past(detect_update[p]))
      else $error("detection flag set without update");
    a_class_valid_sig: assert property (
      $rose(prb_flags[4+p]) |-> $past(detection_result[p*DW +: DW]) == VALID_SIG_CODE)
      else $error("class flag without valid signature");
    a_cls_ignored: assert property (
      class_update[p] && detection_result[p*DW +: DW] != VALID_SIG_CODE && !prb_flags[4+p] |=> !prb_flags[4+p])
      else $error("class flag set without valid signature");
    a_drop_flag_set: assert property (mps_dropout[p] && power_good[p] |=> drp_flags[4+p])
      else $error("dropout did not set flag");
    a_drop_gated: assert property (
      $rose(drp_flags[4+p]) |-> $past(mps_dropout[p] && power_good[p]))
      else $error("dropout flag set on unpowered port");
    a_pcut_flag_set: assert property (
      two_pair_overpower[p] && power_good[p] |=> drp_flags[p])
      else $error("overpower did not set flag");
    a_pcut_gated: assert property (
      $rose(drp_flags[p]) |-> $past(two_pair_overpower[p] && power_good[p]))
      else $error("overpower flag set on unpowered port");
    a_port_clear: assert property (
      port_clear[p] && !mps_dropout[p] && !two_pair_overpower[p] |=> !drp_flags[4+p] && !drp_flags[p])
      else $error("port clear left fault flags set");
    a_take_drop: assert property (
      take_drp && !(mps_dropout[p] && power_good[p]) |=> !drp_flags[4+p])
      else $error("clear-on-read left dropout flag set");
    a_pwr_sticky: assert property (
      pwr_flags[4+p] && !take_pwr && !clear_all && !port_clear[p] |=> pwr_flags[4+p])
      else $error("powered-ok flag dropped without clear");
    a_prb_sticky: assert property (
      prb_flags[p] && !take_prb && !clear_all && !port_clear[p] |=> prb_flags[p])
      else $error("detection flag dropped without clear");
  end

  // ****************************************
  // Read port and change-only checks
  // ****************************************
  a_det_change_only: assert property (
    $rose(prb_flags[0]) |-> $past(detect_update[0]) &&
      (!$past(detect_change_only) || $past(detection_result[DW-1:0]) != $past(g_port[0].u_det.last)))
    else $error("detection flag set without qualifying update");
  a_take_clears: assert property (
    $past(arst_n) && take_pwr && $stable(power_good) && $stable(power_enable) |=> pwr_flags == 8'h00)
    else $error("clear-on-read left power flags set");
  a_take_prb: assert property (
    take_prb && detect_update == 4'h0 && class_update == 4'h0 |=> prb_flags == 8'h00)
    else $error("clear-on-read left probe flags set");
  a_view_keeps: assert property (
    rd_en && rd_addr == pse_pkg::PSE_OFS_DRP_VIEW && !clear_all && port_clear == 4'h0
      |=> (drp_flags & $past(drp_flags)) == $past(drp_flags))
    else $error("read-only view changed flags");
  a_view_pwr: assert property (
    rd_en && rd_addr == pse_pkg::PSE_OFS_PWR_VIEW && !clear_all && port_clear == 4'h0
      |=> (pwr_flags & $past(pwr_flags)) == $past(pwr_flags))
    else $error("read-only view changed power flags");
  a_read_data: assert property (
    rd_en && rd_addr == pse_pkg::PSE_OFS_PRB_VIEW |=> rd_valid && rd_data == $past(prb_flags))
    else $error("read data mismatch");
  a_unmapped_read: assert property (
    rd_en && (rd_addr < pse_pkg::PSE_OFS_PWR_VIEW || rd_addr > pse_pkg::PSE_OFS_DRP_TAKE)
      |=> rd_data == pse_pkg::PSE_RD_UNMAPPED)
    else $error("unmapped read returned data");
  a_rd_valid_pulse: assert property (rd_en |=> rd_valid)
    else $error("read valid missing");
  a_rd_valid_idle: assert property (!rd_en |=> !rd_valid)
    else $error("read valid without request");
  a_rd_data_hold: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data changed without request");

  // ****************************************
  // Summary, link and clear checks
  // ****************************************
  a_sum_pgood: assert property (|pwr_flags[7:4] |=> quad_summary[pse_pkg::PSE_SUM_PGOOD])
    else $error("powered-ok summary missing");
  a_sum_penable: assert property (|pwr_flags[3:0] |=> quad_summary[pse_pkg::PSE_SUM_PENABLE])
    else $error("switch-on summary missing");
  a_sum_class: assert property (|prb_flags[7:4] |=> quad_summary[pse_pkg::PSE_SUM_CLASS])
    else $error("class summary missing");
  a_sum_detect: assert property (|prb_flags[3:0] |=> quad_summary[pse_pkg::PSE_SUM_DETECT])
    else $error("detect summary missing");
  a_sum_drop: assert property (|drp_flags[7:4] |=> quad_summary[pse_pkg::PSE_SUM_DROP])
    else $error("dropout summary missing");
  a_sum_fault: assert property (|drp_flags[3:0] |=> quad_summary[pse_pkg::PSE_SUM_PI_FAULT])
    else $error("fault summary missing");

  a_sum_drop_clear: assert property (drp_flags[7:4] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_DROP])
    else $error("dropout summary held without flags");
  a_sum_fault_clear: assert property (drp_flags[3:0] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_PI_FAULT])
    else $error("fault summary held without flags");
  a_sum_pgood_clear: assert property (pwr_flags[7:4] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_PGOOD])
    else $error("powered-ok summary held without flags");
  a_sum_penable_clear: assert property (pwr_flags[3:0] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_PENABLE])
    else $error("switch-on summary held without flags");
  a_sum_class_clear: assert property (prb_flags[7:4] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_CLASS])
    else $error("class summary held without flags");
  a_sum_detect_clear: assert property (prb_flags[3:0] == 4'h0 |=> !quad_summary[pse_pkg::PSE_SUM_DETECT])
    else $error("detect summary held without flags");
  a_link_update: assert property (
    four_pair_mode[0] && class_update[0] && detection_result[DW-1:0] == VALID_SIG_CODE
      |=> pair_link_check_result[LW-1:0] == $past(link_check_in[LW-1:0]))
    else $error("pair link check not updated");
  a_link_hold0: assert property (!four_pair_mode[0] |=> $stable(pair_link_check_result[LW-1:0]))
    else $error("pair link check changed outside four-pair mode");
  a_link_hold: assert property (!four_pair_mode[1] |=> $stable(pair_link_check_result[2*LW-1:LW]))
    else $error("pair link check changed outside four-pair mode");
  a_clear_all: assert property (
    clear_all && mps_dropout == 4'h0 && two_pair_overpower == 4'h0 |=> drp_flags == 8'h00)
    else $error("clear-all left fault flags set");
  a_clear_all_pwr: assert property (
    $past(arst_n) && clear_all && $stable(power_good) && $stable(power_enable) |=> pwr_flags == 8'h00)
    else $error("clear-all left power flags set");
  a_flag_sticky: assert property (
    pwr_flags[7] && !take_pwr && !clear_all && !port_clear[3] |=> pwr_flags[7])
    else $error("power flag dropped without clear");

  // ****************************************
  // Cover points
  // ****************************************
  c_take_read: cover property (take_prb && prb_flags != 8'h00);
  c_change_only: cover property (detect_update[1] && detect_change_only && !det_hit[1]);
  c_set_and_clear: cover property (take_drp && mps_dropout[0] && power_good[0]);
  c_link_update: cover property (four_pair_mode[0] && cls_hit[0]);
  c_clear_all: cover property (clear_all && pwr_flags != 8'h00);
endmodule : pse_event_regs

// >>> tb/test_pse_event_regs.sv
// Self-checking bench for the quad event flag registers
`timescale 1ns/100ps
module test_pse_event_regs;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0] power_good = 4'h0;
  logic [3:0] power_enable = 4'h0;
  logic [3:0] detect_update = 4'h0;
  logic [15:0] detection_result = 16'h0000;
  logic [3:0] class_update = 4'h0;
  logic [15:0] classification_result = 16'h0000;
  logic detect_change_only = 1'b0;
  logic [1:0] four_pair_mode = 2'h0;
  logic [3:0] link_check_in = 4'h0;
  logic [3:0] pair_link_check_result;
  logic [3:0] mps_dropout = 4'h0;
  logic [3:0] two_pair_overpower = 4'h0;
  logic [3:0] port_clear = 4'h0;
  logic clear_all = 1'b0;
  logic [7:0] quad_summary;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [31:0] r;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // ****************************************
  // Design under test
  // ****************************************
  pse_event_regs dut (.clk(clk), .arst_n(arst_n), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .power_good(power_good), .power_enable(power_enable), .detect_update(detect_update),
    .detection_result(detection_result), .class_update(class_update),
    .classification_result(classification_result), .detect_change_only(detect_change_only),
    .four_pair_mode(four_pair_mode), .link_check_in(link_check_in),
    .pair_link_check_result(pair_link_check_result), .mps_dropout(mps_dropout),
    .two_pair_overpower(two_pair_overpower), .port_clear(port_clear), .clear_all(clear_all),
    .quad_summary(quad_summary));
  // ****************************************
  // Clock, timeout, checking tasks
  // ****************************************
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rd_en = 1'b1;
    rd_addr = a;
    exp_q.push_back({a, x});
    step(1);
    rd_en = 1'b0;
    step(1);
  endtask : rd
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end
  // Result watcher
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unrequested read", 8'h01, 8'h00);
      end else begin
        e = exp_q.pop_front();
        chk($sformatf("register %h", e[15:8]), rd_data, e[7:0]);
      end
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(439));
    step(5);
    arst_n = 1'b1;
    step(1);
    for (int a = 2; a <= 8; a++) begin
      rd(8'(a), 8'h00);
    end
    chk("quad_summary", quad_summary, 8'h00);
    power_good = 4'h5;
    power_enable = 4'hA;
    step(3);
    chk("quad_summary", quad_summary, 8'h03);
    rd(8'h02, 8'h5A);
    rd(8'h03, 8'h5A);
    rd(8'h02, 8'h00);
    step(1);
    chk("quad_summary", quad_summary, 8'h00);
    r = $urandom % 4;
    power_good = 4'h0;
    power_enable[r] = ~power_enable[r];
    step(3);
    rd(8'h03, 8'h50 | (8'h01 << r));
    detection_result = 16'h0444;
    detect_update = 4'hF;
    class_update = 4'h9;
    four_pair_mode = 2'h1;
    r = $urandom;
    link_check_in = r[3:0];
    step(1);
    detect_update = 4'h0;
    class_update = 4'h0;
    step(2);
    chk("quad_summary", quad_summary, 8'h18);
    chk("link check", {4'h0, pair_link_check_result}, {6'h00, r[1:0]});
    rd(8'h05, 8'h1F);
    detect_change_only = 1'b1;
    detect_update = 4'hF;
    step(1);
    detection_result = 16'h0424;
    step(1);
    detect_update = 4'h2;
    step(1);
    detect_update = 4'h0;
    step(1);
    rd(8'h05, 8'h02);
    detect_change_only = 1'b0;
    detect_update = 4'h8;
    step(1);
    detect_update = 4'h0;
    step(1);
    rd(8'h05, 8'h08);
    mps_dropout = 4'h1;
    step(1);
    mps_dropout = 4'h0;
    power_good = 4'hF;
    step(1);
    rd(8'h06, 8'h00);
    mps_dropout = 4'h2;
    two_pair_overpower = 4'h8;
    step(1);
    mps_dropout = 4'h0;
    two_pair_overpower = 4'h0;
    step(2);
    chk("quad_summary", quad_summary, 8'h26);
    rd(8'h06, 8'h28);
    port_clear = 4'h2;
    step(1);
    port_clear = 4'h0;
    rd(8'h06, 8'h08);
    rd(8'h02, 8'hD0);
    clear_all = 1'b1;
    step(1);
    clear_all = 1'b0;
    step(2);
    chk("quad_summary", quad_summary, 8'h00);
    rd(8'h07, 8'h00);
    step(3);
    chk("pending reads", 8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule : test_pse_event_regs
